// ---- inc/lalb_pkg.sv ----
// package for the wake-cycle, cipher-control and battery-monitor register bank
// assumes a 50 MHz system clock and an APB register port with 32-bit data
package lalb_pkg;

  // ==========================================================
  // register indices (byte address = 4 * index)
  localparam logic [4:0] IDX_OP_MODE = 5'h01;
  localparam logic [4:0] IDX_AFC_AES = 5'h0B;
  localparam logic [4:0] IDX_BATTERY = 5'h0C;
  localparam logic [4:0] IDX_WAKE_CFG = 5'h0D;
  localparam logic [4:0] IDX_IDLE_LEN = 5'h0E;
  localparam logic [4:0] IDX_RX_LEN = 5'h0F;
  localparam logic [4:0] IDX_REVISION = 5'h10;

  // ==========================================================
  // field positions
  localparam int POS_WAKE_ENABLE = 6;
  localparam int POS_MODE_LO = 2;
  localparam int POS_FREQ_CORR = 5;
  localparam int POS_CIPHER_GO = 4;
  localparam int POS_CIPHER_DIR = 3;
  localparam int POS_CIPHER_RUN = 2;
  localparam int POS_PREAMBLE = 1;
  localparam int POS_BAT_LIVE = 4;
  localparam int POS_BAT_EN = 3;

  // ==========================================================
  // reset values
  localparam logic [1:0] RST_AFC_UNUSED = 2'h1;
  localparam logic [2:0] RST_BAT_TRIM = 3'h2;
  localparam logic [1:0] RST_IDLE_UNIT = 2'h2;
  localparam logic [1:0] RST_RX_UNIT = 2'h1;
  localparam logic [1:0] RST_END_ACTION = 2'h1;
  localparam logic [7:0] RST_IDLE_COUNT = 8'hF5;
  localparam logic [7:0] RST_RX_COUNT = 8'h20;
  localparam logic [2:0] RST_MODE = 3'h1;

  // ==========================================================
  // codes
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_SYNTH = 3'h2;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_RX = 3'h4;
  localparam logic [1:0] UNIT_SHORT = 2'h1;
  localparam logic [1:0] UNIT_MID = 2'h2;
  localparam logic [1:0] UNIT_LONG = 2'h3;
  localparam logic [1:0] END_STAY_RX = 2'h0;
  localparam logic [1:0] END_TO_MODE = 2'h1;
  localparam logic [1:0] END_RESUME = 2'h2;

  // ==========================================================
  // timing: unit lengths in ns and their cycle counts at 50 MHz
  localparam longint CLK_PERIOD_NS = 20;
  localparam longint UNIT_SHORT_NS = 64000;
  localparam longint UNIT_MID_NS = 4100000;
  localparam longint UNIT_LONG_NS = 262000000;
  localparam int UNIT_SHORT_CYC = int'(UNIT_SHORT_NS / CLK_PERIOD_NS);
  localparam int UNIT_MID_CYC = int'(UNIT_MID_NS / CLK_PERIOD_NS);
  localparam int UNIT_LONG_CYC = int'(UNIT_LONG_NS / CLK_PERIOD_NS);

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [1:0] idle_unit_select;
    logic [1:0] rx_unit_select;
    logic accept_rule_select;
    logic [1:0] wake_cycle_end_action;
  } lalb_wake_cfg_s;

  typedef struct packed {
    logic improved_freq_correction_sel;
    logic cipher_direction;
    logic cipher_running;
    logic preamble_found_flag;
    logic reserved_bit;
  } lalb_afc_s;

endpackage

// ---- src/lalb_regs.sv ----
// register bank: frequency-correction select, cipher control, preamble flag,
// battery detector control and the wake-cycle (listen) sequencer
// assumes APB master on clk, event inputs one cycle wide and synchronous to clk
//
// Operation
// - bit 5 of afc register selects improved frequency-correction routine.
// - writing 1 to bit 4 starts a standalone cipher operation.
// - bit 3 sets cipher direction, 0 decrypt, 1 encrypt.
// - read-only bit 2 reads 1 while cipher runs, 0 when finished.
// - preamble detection sets sticky bit 1; software writes 1 to clear.
// - battery bit 4 shows live comparator output while detector is enabled.
// - battery bit 3 enables the detector; reset value off.
// - battery bits 2-0 select trip level, reset code 010.
// - wake bits 7-6 set idle unit 64us/4.1ms/262ms, reset 10.
// - wake bits 5-4 set receive unit, same codes, reset 01.
// - accept on strength above threshold; bit 3 adds sync match.
// - end action 00 keeps receive and stops cycling; software disables.
// - end action 01 waits packet or timeout then enters mode field.
// - end action 10 waits event, resumes idle, discards buffer next wakeup.
// - idle phase lasts idle count times idle unit, count resets F5.
// - receive phase lasts receive count times receive unit, resets 20.
// - read-only revision: bits 7-4 silicon, bits 3-0 metal mask.
// - mode codes 000 sleep to 100 receive, used after action 01.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module lalb_regs #(
  parameter int UNIT_SHORT_CYCLES = lalb_pkg::UNIT_SHORT_CYC,
  parameter int UNIT_MID_CYCLES = lalb_pkg::UNIT_MID_CYC,
  parameter int UNIT_LONG_CYCLES = lalb_pkg::UNIT_LONG_CYC,
  parameter logic [7:0] REVISION_CODE = 8'h11 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cipher engine and preamble detector
  input wire logic cipher_finish,
  input wire logic preamble_seen,
  output logic cipher_go,
  output logic cipher_encrypt,
  output logic freq_corr_improved,
  // battery detector
  input wire logic battery_comparator,
  output logic battery_enable,
  output logic [2:0] battery_trip_select,
  // receiver status and radio control
  input wire logic strength_above,
  input wire logic sync_match,
  input wire logic packet_complete_event,
  input wire logic rx_timeout_event,
  output logic [2:0] radio_mode,
  output logic rx_buffer_discard
);

  typedef enum {
    ST_OFF,
    ST_IDLE,
    ST_RX,
    ST_HOLD,
    ST_STOPPED
  } lalb_wake_state_e;

  // ==========================================================
  // bus decode
  logic access;
  logic wr_en;
  logic addr_ok;
  logic [4:0] idx;
  logic [7:0] wdat;
  logic [7:0] rdat;
  logic afc_wr;

  lalb_pkg::lalb_afc_s afc;
  lalb_pkg::lalb_wake_cfg_s wake_cfg;
  logic [7:0] idle_phase_count;
  logic [7:0] rx_phase_count;
  logic battery_comparator_live;
  logic wake_enable;
  logic [2:0] mode_field;

  lalb_wake_state_e state;
  lalb_wake_state_e next_state;
  logic [23:0] div_cnt;
  logic [7:0] unit_cnt;
  logic unit_tick;
  logic phase_done;
  logic [1:0] cur_unit;
  logic [7:0] cur_count;
  logic [23:0] unit_len;
  logic accept;
  logic discard_pending;

  assign idx = paddr[6:2];
  assign wdat = pwdata[7:0];
  assign access = psel & penable & pready;
  assign wr_en = access & pwrite & addr_ok;
  assign afc_wr = wr_en && idx == lalb_pkg::IDX_AFC_AES;

  // address map check: aligned word, known index
  always_comb begin
    addr_ok = 1'b0;
    if (paddr[1:0] == 2'h0 && paddr[7] == 1'b0) begin
      case (idx)
        lalb_pkg::IDX_OP_MODE,
        lalb_pkg::IDX_AFC_AES,
        lalb_pkg::IDX_BATTERY,
        lalb_pkg::IDX_WAKE_CFG,
        lalb_pkg::IDX_IDLE_LEN,
        lalb_pkg::IDX_RX_LEN,
        lalb_pkg::IDX_REVISION: addr_ok = 1'b1;
        default: addr_ok = 1'b0;
      endcase
    end
  end

  // read mux; fixed and unused bits read as constants, except afc bit 0, which reads back its written value
  always_comb begin
    rdat = 8'h00;
    case (idx)
      lalb_pkg::IDX_OP_MODE: begin
        rdat[lalb_pkg::POS_WAKE_ENABLE] = wake_enable;
        rdat[lalb_pkg::POS_MODE_LO +: 3] = radio_mode;
      end
      lalb_pkg::IDX_AFC_AES: begin
        rdat[7:6] = lalb_pkg::RST_AFC_UNUSED;
        rdat[lalb_pkg::POS_FREQ_CORR] = afc.improved_freq_correction_sel;
        rdat[lalb_pkg::POS_CIPHER_DIR] = afc.cipher_direction;
        rdat[lalb_pkg::POS_CIPHER_RUN] = afc.cipher_running;
        rdat[lalb_pkg::POS_PREAMBLE] = afc.preamble_found_flag;
        rdat[0] = afc.reserved_bit;
      end
      lalb_pkg::IDX_BATTERY: begin
        rdat[lalb_pkg::POS_BAT_LIVE] = battery_comparator_live;
        rdat[lalb_pkg::POS_BAT_EN] = battery_enable;
        rdat[2:0] = battery_trip_select;
      end
      lalb_pkg::IDX_WAKE_CFG: begin
        rdat[7:1] = wake_cfg;
      end
      lalb_pkg::IDX_IDLE_LEN: rdat = idle_phase_count;
      lalb_pkg::IDX_RX_LEN: rdat = rx_phase_count;
      lalb_pkg::IDX_REVISION: rdat = REVISION_CODE;
      default: rdat = 8'h00;
    endcase
  end

  // ==========================================================
  // apb answer: one wait cycle, ready and data registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel && penable && !pready) begin
        prdata <= (addr_ok && !pwrite) ? {24'h00_0000, rdat} : 32'h0000_0000;
        pslverr <= ~addr_ok;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ==========================================================
  // mode and wake enable register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_enable <= 1'b0;
      mode_field <= lalb_pkg::RST_MODE;
    end else if (wr_en && idx == lalb_pkg::IDX_OP_MODE) begin
      wake_enable <= wdat[lalb_pkg::POS_WAKE_ENABLE];
      mode_field <= wdat[lalb_pkg::POS_MODE_LO +: 3];
    end
  end

  // afc register in one process: start wins over finish, preamble set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      afc <= '0;
      cipher_go <= 1'b0;
    end else begin
      cipher_go <= afc_wr && wdat[lalb_pkg::POS_CIPHER_GO];
      if (afc_wr) begin
        afc.improved_freq_correction_sel <= wdat[lalb_pkg::POS_FREQ_CORR];
        afc.cipher_direction <= wdat[lalb_pkg::POS_CIPHER_DIR];
        afc.reserved_bit <= wdat[0];
      end
      if (afc_wr && wdat[lalb_pkg::POS_CIPHER_GO]) begin
        afc.cipher_running <= 1'b1;
      end else if (cipher_finish) begin
        afc.cipher_running <= 1'b0;
      end
      if (preamble_seen) begin
        afc.preamble_found_flag <= 1'b1;
      end else if (afc_wr && wdat[lalb_pkg::POS_PREAMBLE]) begin
        afc.preamble_found_flag <= 1'b0;
      end
    end
  end

  // battery detector control and live comparator sample
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      battery_enable <= 1'b0;
      battery_trip_select <= lalb_pkg::RST_BAT_TRIM;
      battery_comparator_live <= 1'b0;
    end else begin
      battery_comparator_live <= battery_enable & battery_comparator;
      if (wr_en && idx == lalb_pkg::IDX_BATTERY) begin
        battery_enable <= wdat[lalb_pkg::POS_BAT_EN];
        battery_trip_select <= wdat[2:0];
      end
    end
  end

  // wake-cycle configuration and phase lengths
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_cfg.idle_unit_select <= lalb_pkg::RST_IDLE_UNIT;
      wake_cfg.rx_unit_select <= lalb_pkg::RST_RX_UNIT;
      wake_cfg.accept_rule_select <= 1'b0;
      wake_cfg.wake_cycle_end_action <= lalb_pkg::RST_END_ACTION;
      idle_phase_count <= lalb_pkg::RST_IDLE_COUNT;
      rx_phase_count <= lalb_pkg::RST_RX_COUNT;
    end else if (wr_en) begin
      if (idx == lalb_pkg::IDX_WAKE_CFG) begin
        wake_cfg <= wdat[7:1];
      end
      if (idx == lalb_pkg::IDX_IDLE_LEN) begin
        idle_phase_count <= wdat;
      end
      if (idx == lalb_pkg::IDX_RX_LEN) begin
        rx_phase_count <= wdat;
      end
    end
  end

  assign freq_corr_improved = afc.improved_freq_correction_sel;
  assign cipher_encrypt = afc.cipher_direction;

  // ==========================================================
  // phase timing: unit ticks from a divider, units counted per phase
  always_comb begin
    cur_unit = (state == ST_IDLE) ? wake_cfg.idle_unit_select : wake_cfg.rx_unit_select;
    cur_count = (state == ST_IDLE) ? idle_phase_count : rx_phase_count;
    case (cur_unit)
      lalb_pkg::UNIT_MID: unit_len = 24'(UNIT_MID_CYCLES);
      lalb_pkg::UNIT_LONG: unit_len = 24'(UNIT_LONG_CYCLES);
      default: unit_len = 24'(UNIT_SHORT_CYCLES); // reserved code runs as shortest
    endcase
  end

  assign unit_tick = (div_cnt == unit_len - 24'h00_0001);
  assign phase_done = (cur_count == 8'h00) || (unit_tick && unit_cnt == cur_count - 8'h01);

  // divider and unit counter, restarted on every phase change
  always_ff @(posedge clk) begin
    if (!rst_n || next_state != state) begin
      div_cnt <= 24'h00_0000;
      unit_cnt <= 8'h00;
    end else if (unit_tick) begin
      div_cnt <= 24'h00_0000;
      unit_cnt <= unit_cnt + 8'h01;
    end else begin
      div_cnt <= div_cnt + 24'h00_0001;
    end
  end

  // acceptance criterion
  assign accept = strength_above && (!wake_cfg.accept_rule_select || sync_match);

  // ==========================================================
  // wake-cycle sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: if (wake_enable) next_state = ST_IDLE;
      ST_IDLE: if (phase_done) next_state = ST_RX;
      ST_RX: begin
        if (accept) begin
          if (wake_cfg.wake_cycle_end_action == lalb_pkg::END_STAY_RX) begin
            next_state = ST_STOPPED;
          end else begin
            next_state = ST_HOLD;
          end
        end else if (phase_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (packet_complete_event || rx_timeout_event) begin
          if (wake_cfg.wake_cycle_end_action == lalb_pkg::END_RESUME) begin
            next_state = ST_IDLE;
          end else begin
            next_state = ST_STOPPED;
          end
        end
      end
      ST_STOPPED: next_state = ST_STOPPED;
      default: next_state = ST_OFF;
    endcase
    if (!wake_enable) next_state = ST_OFF;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // radio mode out; stop after action 01 enters the programmed mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      radio_mode <= lalb_pkg::RST_MODE;
    end else begin
      case (next_state)
        ST_IDLE: radio_mode <= lalb_pkg::MODE_SLEEP;
        ST_RX, ST_HOLD: radio_mode <= lalb_pkg::MODE_RX;
        ST_STOPPED: begin
          if (state == ST_HOLD) begin
            radio_mode <= mode_field;
          end else if (state == ST_RX) begin
            radio_mode <= lalb_pkg::MODE_RX;
          end
        end
        default: radio_mode <= mode_field;
      endcase
    end
  end

  // discard of buffered data at the receive wakeup after a resumed cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      discard_pending <= 1'b0;
      rx_buffer_discard <= 1'b0;
    end else begin
      rx_buffer_discard <= 1'b0;
      if (state == ST_HOLD && next_state == ST_IDLE) begin
        discard_pending <= 1'b1;
      end else if (state == ST_IDLE && next_state == ST_RX && discard_pending) begin
        discard_pending <= 1'b0;
        rx_buffer_discard <= 1'b1;
      end else if (next_state == ST_OFF) begin
        discard_pending <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ---- test/lalb_regs_props.sv ----
// checker for the register bank ports: apb timing, control outputs, read data
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module lalb_regs_props #(
  parameter logic [7:0] REVISION_CODE = 8'h11
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // control outputs
  input wire logic cipher_go,
  input wire logic cipher_encrypt,
  input wire logic freq_corr_improved,
  input wire logic battery_enable,
  input wire logic [2:0] battery_trip_select,
  input wire logic [2:0] radio_mode
);
  // ==========================================================
  // helper logic
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic acc;
  logic ok_addr;
  logic [31:0] wd_q;
  logic go_d1;
  logic go_d2;
  // access phase and decode of mapped words
  assign acc = psel && penable;
  assign ok_addr = paddr[1:0] == 2'h0 && !paddr[7] && (paddr[6:2] == lalb_pkg::IDX_OP_MODE
    || (paddr[6:2] >= lalb_pkg::IDX_AFC_AES && paddr[6:2] <= lalb_pkg::IDX_REVISION));
  // last write data and delayed start requests
  always_ff @(posedge clk) begin
    wd_q <= pwdata;
    go_d1 <= acc && pwrite && paddr == 8'h2C && pwdata[4];
    go_d2 <= go_d1;
  end
  // ==========================================================
  // sequences
  sequence s_wait;
    acc && !pready;
  endsequence
  sequence s_wr_afc;
    acc && pready && pwrite && paddr == 8'h2C;
  endsequence
  sequence s_wr_bat;
    acc && pready && pwrite && paddr == 8'h30;
  endsequence
  // ==========================================================
  // assertions
  a_one_wait: assert property (s_wait |=> pready)
    else $error("pready did not follow the access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_bad_addr: assert property (acc && pready |-> pslverr == !ok_addr)
    else $error("pslverr does not match the address decode");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_rev_value: assert property (acc && pready && !pwrite && paddr == 8'h40 |->
    prdata[7:0] == REVISION_CODE)
    else $error("revision read wrong");
  a_go_single: assert property (cipher_go |=> !cipher_go)
    else $error("start strobe longer than one cycle");
  a_go_cause: assert property (cipher_go |-> go_d1 || go_d2)
    else $error("start strobe without a start write");
  a_dir_level: assert property (s_wr_afc |=> cipher_encrypt == wd_q[3]
    && freq_corr_improved == wd_q[5])
    else $error("direction or correction select not updated");
  a_bat_write: assert property (s_wr_bat |=> battery_enable == wd_q[3]
    && battery_trip_select == wd_q[2:0])
    else $error("battery controls not updated");
  a_reset_vals: assert property ($rose(rst_n) |-> !battery_enable && !cipher_go
    && battery_trip_select == lalb_pkg::RST_BAT_TRIM && radio_mode == lalb_pkg::MODE_STANDBY)
    else $error("reset values wrong");
endmodule

bind lalb_regs lalb_regs_props #(.REVISION_CODE(REVISION_CODE)) u_props (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cipher_go(cipher_go), .cipher_encrypt(cipher_encrypt),
  .freq_corr_improved(freq_corr_improved), .battery_enable(battery_enable),
  .battery_trip_select(battery_trip_select), .radio_mode(radio_mode)
);
`default_nettype wire

// ---- test/lalb_regs_tb_top.sv ----
// self-checking bench: apb access, cipher control, battery, wake cycle
// assumes lalb_regs with shortened unit lengths and the bound checker
`timescale 1ns/1ps
`default_nettype none

module lalb_regs_tb_top;
  localparam logic [7:0] REV = 8'h5A; // arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic fin = 1'b0;
  logic pre = 1'b0;
  logic cmp = 1'b0;
  logic str = 1'b0;
  logic syn = 1'b0;
  logic pkt = 1'b0;
  logic tmo = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, go, enc, fcorr, bat_en, disc;
  logic [2:0] trip, mode;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int comparisons = 0;
  int go_seen = 0;
  int disc_seen = 0;

  // ==========================================================
  // clock, strobe counters and design
  always #10 clk = ~clk;
  // count one-cycle strobes
  always @(posedge clk) begin
    if (go === 1'b1) go_seen++;
    if (disc === 1'b1) disc_seen++;
  end
  lalb_regs #(.UNIT_SHORT_CYCLES(4), .UNIT_MID_CYCLES(8), .UNIT_LONG_CYCLES(16),
    .REVISION_CODE(REV)) dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cipher_finish(fin), .preamble_seen(pre), .cipher_go(go), .cipher_encrypt(enc),
    .freq_corr_improved(fcorr), .battery_comparator(cmp), .battery_enable(bat_en),
    .battery_trip_select(trip), .strength_above(str), .sync_match(syn),
    .packet_complete_event(pkt), .rx_timeout_event(tmo), .radio_mode(mode),
    .rx_buffer_discard(disc));

  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), {24'h0, exp}, rd);
    chk("read error", 0, err);
  endtask
  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    while (mode !== m && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("mode reached", m, mode);
  endtask
  task automatic hold_len(input logic [2:0] m, input int exp);
    int n;
    n = 0;
    while (mode === m && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("phase length", exp, n);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rchk(8'h2C, 8'h40);
    rchk(8'h30, 8'h02);
    rchk(8'h34, 8'h92);
    rchk(8'h38, 8'hF5);
    rchk(8'h3C, 8'h20);
    apb(1'b1, 8'h40, 8'h00);
    rchk(8'h40, REV);
    apb(1'b0, 8'h44, 8'h00);
    chk("unmapped error", 1, err);
    $display("test reset done");
  endtask
  task automatic t_afc;
    int g;
    g = go_seen;
    apb(1'b1, 8'h2C, 8'hFF);
    chk("encrypt", 1, enc);
    chk("freq corr", 1, fcorr);
    rchk(8'h2C, 8'h6D);
    chk("go pulses", g + 1, go_seen);
    fin <= 1'b1;
    @(posedge clk);
    fin <= 1'b0;
    pre <= 1'b1;
    @(posedge clk);
    pre <= 1'b0;
    rchk(8'h2C, 8'h6B);
    apb(1'b1, 8'h2C, 8'h02);
    rchk(8'h2C, 8'h40);
    chk("encrypt off", 0, enc);
    $display("test cipher done");
  endtask
  task automatic t_bat;
    for (int t = 0; t < 8; t++) begin
      apb(1'b1, 8'h30, 8'hE8 | 8'(t));
      chk("trip", t, trip);
    end
    chk("detector on", 1, bat_en);
    cmp <= 1'b1;
    rchk(8'h30, 8'h1F);
    cmp <= 1'b0;
    rchk(8'h30, 8'h0F);
    cmp <= 1'b1;
    apb(1'b1, 8'h30, 8'h07);
    rchk(8'h30, 8'h07);
    $display("test battery done");
  endtask
  task automatic t_cycle;
    apb(1'b1, 8'h38, 8'h03);
    apb(1'b1, 8'h3C, 8'h02);
    for (int u = 1; u < 4; u++) begin
      apb(1'b1, 8'h34, 8'(u * 64 + 8'h12));
      apb(1'b1, 8'h04, 8'h44);
      wait_mode(lalb_pkg::MODE_RX);
      hold_len(lalb_pkg::MODE_RX, 8);
      hold_len(lalb_pkg::MODE_SLEEP, 3 * (4 << (u - 1)));
      apb(1'b1, 8'h04, 8'h04);
    end
    $display("test cycle done");
  endtask
  task automatic t_accept;
    int d;
    str <= 1'b1;
    apb(1'b1, 8'h34, 8'h5A);
    apb(1'b1, 8'h04, 8'h48);
    wait_mode(lalb_pkg::MODE_RX);
    hold_len(lalb_pkg::MODE_RX, 8);
    syn <= 1'b1;
    wait_mode(lalb_pkg::MODE_RX);
    repeat (10) @(posedge clk);
    chk("held rx", lalb_pkg::MODE_RX, mode);
    pkt <= 1'b1;
    @(posedge clk);
    pkt <= 1'b0;
    repeat (30) @(posedge clk);
    chk("end mode", lalb_pkg::MODE_SYNTH, mode);
    apb(1'b1, 8'h04, 8'h04);
    syn <= 1'b0;
    apb(1'b1, 8'h34, 8'h50);
    apb(1'b1, 8'h04, 8'h44);
    wait_mode(lalb_pkg::MODE_RX);
    tmo <= 1'b1;
    @(posedge clk);
    tmo <= 1'b0;
    repeat (10) @(posedge clk);
    chk("stay rx", lalb_pkg::MODE_RX, mode);
    apb(1'b1, 8'h04, 8'h04);
    syn <= 1'b1;
    d = disc_seen;
    apb(1'b1, 8'h34, 8'h5C);
    apb(1'b1, 8'h04, 8'h44);
    wait_mode(lalb_pkg::MODE_RX);
    repeat (10) @(posedge clk);
    pkt <= 1'b1;
    @(posedge clk);
    pkt <= 1'b0;
    wait_mode(lalb_pkg::MODE_SLEEP);
    wait_mode(lalb_pkg::MODE_RX);
    repeat (3) @(posedge clk);
    chk("discards", d + 1, disc_seen);
    apb(1'b1, 8'h04, 8'h04);
    $display("test accept done");
  endtask

  // ==========================================================
  // verdict, watchdog and main sequence
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // cut a hang short
  initial begin
    #1000000;
    fails++;
    summarize();
  end
  // reset, then the scenarios
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_afc();
    t_bat();
    t_cycle();
    t_accept();
    summarize();
  end
endmodule
`default_nettype wire
